// ---- hw/ufc_regs_cfg.svh ----
`ifndef UFC_REGS_CFG_SVH
`define UFC_REGS_CFG_SVH

// register byte addresses
`define UFC_ADDR_FWD_CTRL 8'h68
`define UFC_ADDR_CARD_VID 8'h6c
`define UFC_ADDR_UP3_UPPER 8'h64
// field positions in the shared word at 68h
`define UFC_TX_TERM_LSB 12
`define UFC_RX_TERM_LSB 14
`define UFC_PAGE_LSB 16
`define UFC_PAGE_EXT_BIT 20
`define UFC_FWD64_BIT 21
`define UFC_SPLIT_LSB 30
// reset values
`define UFC_TX_TERM_RST 2'h0
`define UFC_RX_TERM_RST 2'h0
`define UFC_PAGE_RST 4'h0
`define UFC_PAGE_EXT_RST 1'h0
`define UFC_FWD64_RST 1'h0
`define UFC_SPLIT_RST 2'h2
`define UFC_UP3_UPPER_RST 32'h0
// arbitrary neutral identity value
`define UFC_CARD_VID_DEF 16'h5a5a
// page size table bases (log2 of bytes)
`define UFC_PAGE_LOG2_NORMAL 6'h07
`define UFC_PAGE_LOG2_COARSE 6'h16
// split boundaries in bytes
`define UFC_SPLIT_32 8'h20
`define UFC_SPLIT_64 8'h40
`define UFC_SPLIT_128 8'h80
// axi responses
`define UFC_RESP_OKAY 2'h0
`define UFC_RESP_SLVERR 2'h2

`endif

// ---- hw/ufc_pkg.sv ----
package ufc_pkg;

    // settings word as consumed by the forwarding datapath
    typedef struct packed {
        logic [1:0] tx_term;
        logic [1:0] rx_term;
        logic [3:0] page_code;
        logic page_ext;
        logic fwd64_en;
        logic [1:0] split_sel;
    } ufc_ctrl_t;

    // decoded forwarding view
    typedef struct packed {
        logic win2_en;
        logic [5:0] page_log2;
        logic [7:0] split_bytes;
        logic fwd64_by_range;
    } ufc_decode_t;

endpackage

// ---- hw/ufc_decode.sv ----
`timescale 1ns/10ps
`include "ufc_regs_cfg.svh"

module ufc_decode
    import ufc_pkg::*;
(
    input wire ufc_pkg::ufc_ctrl_t ctrl_i,
    output ufc_pkg::ufc_decode_t dec_o
);
    import ufc_pkg::*;

    // page table and split decode
    always_comb
    begin
        dec_o = '0;
        dec_o.fwd64_by_range = ctrl_i.fwd64_en;
        if (ctrl_i.page_code == 4'h0)
        begin
            dec_o.win2_en = 1'b0;
        end
        else if (!ctrl_i.page_ext)
        begin
            dec_o.win2_en = 1'b1;
            dec_o.page_log2 = `UFC_PAGE_LOG2_NORMAL + {2'h0, ctrl_i.page_code};
        end
        else if (ctrl_i.page_code[3:2] == 2'h0)
        begin
            dec_o.win2_en = 1'b1;
            dec_o.page_log2 = `UFC_PAGE_LOG2_COARSE + {2'h0, ctrl_i.page_code};
        end
        if (ctrl_i.split_sel[1])
        begin
            dec_o.split_bytes = `UFC_SPLIT_128;
        end
        else if (ctrl_i.split_sel[0])
        begin
            dec_o.split_bytes = `UFC_SPLIT_64;
        end
        else
        begin
            dec_o.split_bytes = `UFC_SPLIT_32;
        end
    end

endmodule

// ---- hw/ufc_regs.sv ----
// Operation
// - tx termination select at bits 13:12, reset 00.
// - rx termination select at bits 15:14, reset 00.
// - extension clear: page codes 1..15 give 256 bytes doubling to 4M.
// - extension set: codes 1..3 give 8M..32M; 01xx and 1xxx disable window two.
// - page code 0000 disables window two; field resets to zero.
// - bit 20 picks normal or coarse page table, reset 0.
// - bit 21 picks upstream 64-bit forwarding by range, reset 0.
// - bits 31:30 pick write split boundary 32/64/128, reset 10.
// - read-only card vendor id at 6Ch bits 15:0.
// - 64-bit compare takes upper base from register at 64h.
`timescale 1ns/10ps
`include "ufc_regs_cfg.svh"

module ufc_regs
    import ufc_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter logic [15:0] CARD_VID = `UFC_CARD_VID_DEF
)
(
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output ufc_pkg::ufc_ctrl_t ctrl_o,
    output ufc_pkg::ufc_decode_t dec_o,
    output logic [31:0] up3_upper_base_o
);
    import ufc_pkg::*;

    // refuse address widths that the byte-address decode cannot serve
    if (ADDR_W < 8 || ADDR_W > 32)
    begin : g_addr_w_check
        $error("ADDR_W must be 8..32");
    end

    logic aw_held_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic w_held_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    ufc_ctrl_t ctrl_reg;
    logic [31:0] up3_upper_reg;
    logic do_write;
    logic [7:0] wr_addr;
    logic [7:0] rd_addr;
    logic [31:0] word68;
    logic [31:0] rd_next;

    assign wr_addr = aw_addr_reg[7:0];
    assign rd_addr = s_axi_araddr_i[7:0];

    // ready while the slot is empty and no response is pending
    assign s_axi_awready_o = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready_o = !w_held_reg && !bvalid_reg;
    assign s_axi_arready_o = !rvalid_reg;
    assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;

    // capture write address
    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= '0;
        end
        else if (s_axi_awvalid_i && s_axi_awready_o)
        begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr_i;
        end
        else if (do_write)
        begin
            aw_held_reg <= 1'b0;
        end
    end

    // capture write data
    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
        end
        else if (s_axi_wvalid_i && s_axi_wready_o)
        begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata_i;
            w_strb_reg <= s_axi_wstrb_i;
        end
        else if (do_write)
        begin
            w_held_reg <= 1'b0;
        end
    end

    // write response
    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            bvalid_reg <= 1'b0;
            bresp_reg <= `UFC_RESP_OKAY;
        end
        else if (do_write)
        begin
            bvalid_reg <= 1'b1;
            if (wr_addr == `UFC_ADDR_FWD_CTRL || wr_addr == `UFC_ADDR_CARD_VID
                || wr_addr == `UFC_ADDR_UP3_UPPER)
            begin
                bresp_reg <= `UFC_RESP_OKAY;
            end
            else
            begin
                bresp_reg <= `UFC_RESP_SLVERR;
            end
        end
        else if (s_axi_bready_i)
        begin
            bvalid_reg <= 1'b0;
        end
    end

    // fields of the shared word at 68h
    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            ctrl_reg.tx_term <= `UFC_TX_TERM_RST;
            ctrl_reg.rx_term <= `UFC_RX_TERM_RST;
            ctrl_reg.page_code <= `UFC_PAGE_RST;
            ctrl_reg.page_ext <= `UFC_PAGE_EXT_RST;
            ctrl_reg.fwd64_en <= `UFC_FWD64_RST;
            ctrl_reg.split_sel <= `UFC_SPLIT_RST;
        end
        else if (do_write && wr_addr == `UFC_ADDR_FWD_CTRL)
        begin
            if (w_strb_reg[1])
            begin
                ctrl_reg.tx_term <= w_data_reg[`UFC_TX_TERM_LSB +: 2];
                ctrl_reg.rx_term <= w_data_reg[`UFC_RX_TERM_LSB +: 2];
            end
            if (w_strb_reg[2])
            begin
                ctrl_reg.page_code <= w_data_reg[`UFC_PAGE_LSB +: 4];
                ctrl_reg.page_ext <= w_data_reg[`UFC_PAGE_EXT_BIT];
                ctrl_reg.fwd64_en <= w_data_reg[`UFC_FWD64_BIT];
            end
            if (w_strb_reg[3])
            begin
                ctrl_reg.split_sel <= w_data_reg[`UFC_SPLIT_LSB +: 2];
            end
        end
    end

    // upper base for the third upstream range
    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            up3_upper_reg <= `UFC_UP3_UPPER_RST;
        end
        else if (do_write && wr_addr == `UFC_ADDR_UP3_UPPER)
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (w_strb_reg[i])
                begin
                    up3_upper_reg[i*8 +: 8] <= w_data_reg[i*8 +: 8];
                end
            end
        end
    end

    // read view of the shared word, unlisted bits read zero
    always_comb
    begin
        word68 = 32'h0;
        word68[`UFC_TX_TERM_LSB +: 2] = ctrl_reg.tx_term;
        word68[`UFC_RX_TERM_LSB +: 2] = ctrl_reg.rx_term;
        word68[`UFC_PAGE_LSB +: 4] = ctrl_reg.page_code;
        word68[`UFC_PAGE_EXT_BIT] = ctrl_reg.page_ext;
        word68[`UFC_FWD64_BIT] = ctrl_reg.fwd64_en;
        word68[`UFC_SPLIT_LSB +: 2] = ctrl_reg.split_sel;
    end

    // read mux
    always_comb
    begin
        rd_next = 32'h0;
        case (rd_addr)
            `UFC_ADDR_FWD_CTRL: rd_next = word68;
            `UFC_ADDR_CARD_VID: rd_next = {16'h0, CARD_VID};
            `UFC_ADDR_UP3_UPPER: rd_next = up3_upper_reg;
            default: rd_next = 32'h0;
        endcase
    end

    // read response
    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= `UFC_RESP_OKAY;
        end
        else if (s_axi_arvalid_i && s_axi_arready_o)
        begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_next;
            if (rd_addr == `UFC_ADDR_FWD_CTRL || rd_addr == `UFC_ADDR_CARD_VID
                || rd_addr == `UFC_ADDR_UP3_UPPER)
            begin
                rresp_reg <= `UFC_RESP_OKAY;
            end
            else
            begin
                rresp_reg <= `UFC_RESP_SLVERR;
            end
        end
        else if (s_axi_rready_i)
        begin
            rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_bvalid_o = bvalid_reg;
    assign s_axi_bresp_o = bresp_reg;
    assign s_axi_rvalid_o = rvalid_reg;
    assign s_axi_rdata_o = rdata_reg;
    assign s_axi_rresp_o = rresp_reg;
    assign ctrl_o = ctrl_reg;
    assign up3_upper_base_o = up3_upper_reg;

    // page and split decode
    ufc_decode u_decode
    (
        .ctrl_i(ctrl_reg),
        .dec_o(dec_o)
    );

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!nrst_i);

    sequence s_wr68;
        do_write && wr_addr == `UFC_ADDR_FWD_CTRL;
    endsequence

    property p_tx_term;
        s_wr68 and w_strb_reg[1] |=> ctrl_o.tx_term == $past(w_data_reg[13:12]);
    endproperty
    a_tx_term: assert property (p_tx_term) else $error("tx term not written");

    property p_rx_term;
        s_wr68 and w_strb_reg[1] |=> ctrl_o.rx_term == $past(w_data_reg[15:14]);
    endproperty
    a_rx_term: assert property (p_rx_term) else $error("rx term not written");

    property p_page_normal;
        !ctrl_o.page_ext && ctrl_o.page_code != 4'h0
            |-> dec_o.win2_en && dec_o.page_log2 == 6'h07 + {2'h0, ctrl_o.page_code};
    endproperty
    a_page_normal: assert property (p_page_normal) else $error("normal page size wrong");

    property p_page_coarse;
        ctrl_o.page_ext |-> dec_o.win2_en == (ctrl_o.page_code inside {4'h1, 4'h2, 4'h3});
    endproperty
    a_page_coarse: assert property (p_page_coarse) else $error("coarse window enable wrong");

    property p_page_zero;
        ctrl_o.page_code == 4'h0 |-> !dec_o.win2_en;
    endproperty
    a_page_zero: assert property (p_page_zero) else $error("code zero must disable");

    property p_split;
        1'b1 |-> dec_o.split_bytes == (ctrl_o.split_sel[1] ? 8'h80 :
            (ctrl_o.split_sel[0] ? 8'h40 : 8'h20));
    endproperty
    a_split: assert property (p_split) else $error("split boundary wrong");

    property p_vid_read;
        s_axi_arvalid_i && s_axi_arready_o && rd_addr == 8'h6c
            |=> s_axi_rvalid_o && s_axi_rdata_o == {16'h0, CARD_VID};
    endproperty
    a_vid_read: assert property (p_vid_read) else $error("vendor id read wrong");

    property p_lane_keep;
        s_wr68 and !w_strb_reg[3] |=> $stable(ctrl_o.split_sel);
    endproperty
    a_lane_keep: assert property (p_lane_keep) else $error("disabled lane changed");

    property p_ext_fwd;
        s_wr68 and w_strb_reg[2] |=> ctrl_o.page_ext == $past(w_data_reg[20])
            && ctrl_o.fwd64_en == $past(w_data_reg[21]);
    endproperty
    a_ext_fwd: assert property (p_ext_fwd) else $error("bits 20/21 not written");

    property p_lane1_keep;
        s_wr68 and !w_strb_reg[1] |=> $stable(ctrl_o.tx_term) && $stable(ctrl_o.rx_term);
    endproperty
    a_lane1_keep: assert property (p_lane1_keep) else $error("lane one changed");

    property p_upper_write;
        do_write && wr_addr == `UFC_ADDR_UP3_UPPER && w_strb_reg == 4'hf
            |=> up3_upper_base_o == $past(w_data_reg);
    endproperty
    a_upper_write: assert property (p_upper_write) else $error("upper base not written");

    property p_vid_write;
        do_write && wr_addr == `UFC_ADDR_CARD_VID |=> $stable(ctrl_o) && $stable(up3_upper_base_o);
    endproperty
    a_vid_write: assert property (p_vid_write) else $error("vendor write had side effect");

endmodule

// ---- verification/tb.sv ----
`timescale 1ns/10ps
`include "ufc_regs_cfg.svh"

module tb;
    import ufc_pkg::*;
    logic core_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, up3;
    ufc_ctrl_t ctrl;
    ufc_decode_t dec;
    int err_total = 0;
    int checks = 0;
    int cyc = 0;

    // device under test with a known card vendor value
    ufc_regs #(.ADDR_W(8), .CARD_VID(16'h1234)) ufc_regs_inst (
        .core_clk_i(core_clk_i), .nrst_i(nrst_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .ctrl_o(ctrl), .dec_o(dec), .up3_upper_base_o(up3)
    );

    // 25 MHz clock
    always #20 core_clk_i = ~core_clk_i;

    // hang guard
    always @(posedge core_clk_i)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_total++;
            finish_test();
        end
    end

    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // verdict and end of run
    task automatic finish_test();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // reset held for five cycles
    task automatic rst();
        nrst_i <= 1'b0;
        repeat (5) @(posedge core_clk_i);
        nrst_i <= 1'b1;
    endtask

    // one write; handshakes sampled at the settled low phase
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic [1:0] er);
        logic ap, wp, bp, ah, wh, bh;
        ap = 1'b1;
        wp = 1'b1;
        bp = 1'b1;
        @(posedge core_clk_i);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (ap || wp || bp)
        begin
            @(negedge core_clk_i);
            ah = ap && awready;
            wh = wp && wready;
            bh = bp && bvalid;
            if (bh)
                chk(32'(bresp), 32'(er));
            @(posedge core_clk_i);
            if (ah)
                awvalid <= 1'b0;
            if (wh)
                wvalid <= 1'b0;
            if (bh)
                bready <= 1'b0;
            ap = ap && !ah;
            wp = wp && !wh;
            bp = bp && !bh;
        end
    endtask

    // one read, data and response checked
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ap, rp, ah, rh;
        ap = 1'b1;
        rp = 1'b1;
        @(posedge core_clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (ap || rp)
        begin
            @(negedge core_clk_i);
            ah = ap && arready;
            rh = rp && rvalid;
            if (rh)
                chk(rdata, ed);
            if (rh)
                chk(32'(rresp), 32'(er));
            @(posedge core_clk_i);
            if (ah)
                arvalid <= 1'b0;
            if (rh)
                rready <= 1'b0;
            ap = ap && !ah;
            rp = rp && !rh;
        end
    endtask

    // reset values at the ports and through the bus
    task automatic t_reset();
        rst();
        @(negedge core_clk_i);
        chk(32'(ctrl), 32'h002); // reset fields
        chk(32'(dec.win2_en), 32'h0); // window off
        chk(up3, 32'h0); // upper base cleared
        rd(8'h68, 32'h80000000, `UFC_RESP_OKAY); // shared word
        rd(8'h6c, 32'h00001234, `UFC_RESP_OKAY); // vendor word
    endtask

    // byte lanes, terminations, split codes, 64-bit enable
    task automatic t_lanes();
        logic [7:0] sb;
        wr(8'h68, 32'hffffffff, 4'hf, `UFC_RESP_OKAY);
        rd(8'h68, 32'hc03ff000, `UFC_RESP_OKAY); // writable bits
        wr(8'h68, 32'h0, 4'b0010, `UFC_RESP_OKAY);
        rd(8'h68, 32'hc03f0000, `UFC_RESP_OKAY); // lane one only
        wr(8'h68, 32'h00006000, 4'b0010, `UFC_RESP_OKAY);
        @(negedge core_clk_i);
        chk(32'(ctrl.tx_term), 32'h2); // transmit select
        chk(32'(ctrl.rx_term), 32'h1); // receive select
        chk(32'(dec.fwd64_by_range), 32'h1); // range forwarding on
        wr(8'h68, 32'h0, 4'b1011, `UFC_RESP_OKAY);
        rd(8'h68, 32'h003f0000, `UFC_RESP_OKAY); // lane two kept
        for (int c = 0; c < 4; c++)
        begin
            wr(8'h68, {c[1:0], 30'h0}, 4'b1000, `UFC_RESP_OKAY);
            sb = c[1] ? 8'h80 : (c[0] ? 8'h40 : 8'h20);
            @(negedge core_clk_i);
            chk(32'(ctrl.split_sel), 32'(c[1:0])); // split code
            chk(32'(dec.split_bytes), 32'(sb)); // split boundary
        end
        wr(8'h68, 32'h0, 4'b0100, `UFC_RESP_OKAY);
        @(negedge core_clk_i);
        chk(32'(dec.fwd64_by_range), 32'h0); // range forwarding off
    endtask

    // every page code in both tables
    task automatic t_page();
        logic [5:0] lg;
        logic en;
        for (int e = 0; e < 2; e++)
            for (int c = 0; c < 16; c++)
            begin
                wr(8'h68, {11'h0, e[0], c[3:0], 16'h0}, 4'b0100, `UFC_RESP_OKAY);
                en = (c != 0) && (e == 0 || c < 4);
                lg = (e == 1) ? 6'(22 + c) : 6'(7 + c);
                @(negedge core_clk_i);
                chk(32'(dec.win2_en), 32'(en)); // window enable
                if (en)
                    chk(32'(dec.page_log2), 32'(lg)); // page size
                chk(32'(ctrl.page_ext), 32'(e)); // table select
            end
    endtask

    // read-only vendor word and an unmapped place
    task automatic t_ro();
        wr(8'h6c, 32'hffffffff, 4'hf, `UFC_RESP_OKAY); // write accepted
        rd(8'h6c, 32'h00001234, `UFC_RESP_OKAY); // value unchanged
        wr(8'h70, 32'hffffffff, 4'hf, `UFC_RESP_SLVERR);
        rd(8'h70, 32'h0, `UFC_RESP_SLVERR);
        rd(8'h68, 32'hc0000000 | 32'h001f0000, `UFC_RESP_OKAY); // no side effect
    endtask

    // upper base feeding the 64-bit compare
    task automatic t_upper();
        wr(8'h64, 32'hdeadbeef, 4'hf, `UFC_RESP_OKAY);
        @(negedge core_clk_i);
        chk(up3, 32'hdeadbeef); // upper base out
        rd(8'h64, 32'hdeadbeef, `UFC_RESP_OKAY); // upper base word
    endtask

    // main sequence, second reset at the end before the verdict
    initial
    begin
        t_reset();
        t_lanes();
        t_page();
        t_ro();
        t_upper();
        t_reset();
        finish_test();
    end
endmodule
